// ==== common/dsuni_pkg.sv ====
// Purpose: constants and types for the global control register group
// Assumes: 8-bit host registers, 125 MHz system clock
// Notes:   identification values are arbitrary
package dsuni_pkg;
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 8;
  localparam logic [7:0]  OFF_MODE    = 8'h00;
  localparam logic [7:0]  OFF_IO      = 8'h01;
  localparam logic [7:0]  OFF_PART    = 8'h02;
  localparam logic [7:0]  OFF_REV     = 8'h03;
  localparam logic [7:0]  OFF_ISUM    = 8'h05;
  localparam logic [7:0]  OFF_TEST    = 8'h06;
  // arbitrary neutral identification values
  localparam logic [7:0]  PART_ID     = 8'hA5;
  localparam logic [7:0]  REV_ID      = 8'h5A;
  localparam logic [7:0]  MODE_RST    = 8'h0B;
  localparam logic [7:0]  IO_RST      = 8'hA0;
  localparam logic [7:0]  TEST_RST    = 8'h00;
  localparam logic [7:0]  ZERO8       = 8'h00;
  localparam int MB_LLB = 7, MB_CLB = 6, MB_PLB = 5, MB_RST = 4;
  localparam int MB_NOPLCP = 3, MB_FMT = 2, MB_TR1 = 1, MB_TR0 = 0;
  localparam int IB_LOCOFF = 7, IB_LOC = 6, IB_IENCLR = 5, IB_ZSOFF = 4;
  localparam int IB_SRAIL = 3, IB_TXINV = 2, IB_RXINV = 1, IB_FORCE_FRAME_SEARCH = 0;
  localparam int TB_CLEAR = 7, TB_OHIN = 6, TB_EN = 4, TB_ONESHOT = 2;
  localparam int TB_DONE = 1, TB_LOCK = 0;
  localparam int SB_PLCP = 6, SB_ONESEC = 0;
  // summary bits that are idle outside ATM mode: 6..2
  localparam logic [7:1]  ATM_ONLY    = 7'h3E;
  localparam int          BURST_CELLS = 1024;
  localparam int          CNT_W       = 11;
  localparam int          CLK_NS      = 8;
  localparam int          LOC_NS      = 1000;
  localparam int          LOC_CYC     = (LOC_NS + CLK_NS - 1) / CLK_NS;
  localparam int          LOC_W       = 8;

  typedef enum logic [1:0] {
    DSUNI_PLCP_LOOP, DSUNI_PLCP_REF8K, DSUNI_PLCP_STUFPIN, DSUNI_PLCP_FIXED
  } dsuni_plcp_tm_e;
  typedef enum logic [1:0] {
    DSUNI_FR_LOOP, DSUNI_FR_ASYNC, DSUNI_FR_EXTREF, DSUNI_FR_ASYNC2
  } dsuni_fr_tm_e;

  typedef struct packed {
    logic           cell_loopback;
    logic           plcp_loopback;
    logic           plcp_enable;
    logic           framing_format_select;
    dsuni_plcp_tm_e plcp_timing;
    dsuni_fr_tm_e   framer_timing;
    logic           zero_substitution_enable;
    logic           single_rail;
    logic           tx_clock_invert;
    logic           rx_clock_invert;
    logic           clear_channel;
    logic           overhead_in_enable;
    logic           test_gen_enable;
    logic           test_rcv_enable;
    logic           ien_auto_clear;
  } dsuni_cfg_s;
endpackage

// ==== core/dsuni_global_regs.sv ====
// Purpose: global mode, line I/O, identification, summary and test control
// Assumes: host strobes and sub-block inputs are on i_clk_sys
// Notes:   line clocks are pins, synchronised before the loss detector
`timescale 1ns/1ps
`default_nettype none
// Contract
// - mode bit 7 loops outgoing line rails into receive rail inputs
// - mode bit 6 loops receive cells into transmit FIFO, ATM mode only
// - mode bit 5 loops transmit PLCP into receive PLCP, ATM PLCP only
// - rising edge of mode bit 4 resets the whole device
// - mode bit 3 set disables both PLCP processors, ATM mode only
// - mode bit 2 selects C-bit parity (0) or M13 (1) framing
// - PLCP transmit timing: loop, 8 kHz ref, stuff pin, fixed pattern
// - framer transmit timing: loop, external reference, or asynchronous
// - I/O bit 7 disables clock loss detect; bit 6 reports missing clock
// - I/O bit 5 makes status reads clear active interrupt enables
// - I/O bit 4 low enables zero substitution; needs dual rail
// - I/O bit 3 selects dual rail (0) or single rail (1)
// - I/O bit 2 picks transmit clock edge for outgoing rails
// - I/O bit 1 picks receive clock edge for incoming rails
// - rising edge of I/O bit 0 forces receive framer frame search
// - fixed read-only part code at 0x02 and revision at 0x03
// - summary bits 7..1 show pending sub-blocks; ATM-only off otherwise
// - summary bit 0 set by one-second tick, cleared by reading
// - test bit 7 selects ATM UNI (0) or clear channel (1)
// - test bit 6 lets serial payload pin carry overhead in ATM mode
// - ATM mode test bit 4 enables test cell insertion and PRBS lock
// - clear channel test bit 4 enables PRBS generator and receiver
// - ATM mode one-shot: each enable rise gives 1024 cells unless enable drops first, else continuous
module dsuni_global_regs #(
  parameter int LOC_CYCLES = dsuni_pkg::LOC_CYC,
  parameter int BURST      = dsuni_pkg::BURST_CELLS
) (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_rst_n,
  input  wire logic [7:0]            i_addr,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  input  wire logic [7:0]            i_wdata,
  output var  logic [7:0]            o_rdata,
  output var  dsuni_pkg::dsuni_cfg_s o_cfg,
  output var  logic                  o_soft_reset,
  output var  logic                  o_force_frame_search,
  input  wire logic [7:1]            i_block_pending,
  input  wire logic                  i_one_second_tick,
  input  wire logic                  i_test_cell_sent,
  input  wire logic                  i_prbs_lock,
  input  wire logic                  i_transmit_line_clock,
  input  wire logic                  i_receive_line_clock,
  input  wire logic                  i_tx_line_out_positive_rail,
  input  wire logic                  i_tx_line_out_negative_rail,
  input  wire logic                  i_line_in_positive_rail,
  input  wire logic                  i_line_in_negative_rail,
  output logic                       o_rx_positive_rail,
  output logic                       o_rx_negative_rail
);
  localparam int CNT_W = dsuni_pkg::CNT_W;
  localparam int LOC_W = dsuni_pkg::LOC_W;
  localparam logic [LOC_W-1:0] LOC_MAX = LOC_W'(LOC_CYCLES);
  localparam logic [CNT_W-1:0] BURST_N = CNT_W'(BURST);

  logic [7:0]       mode_reg;
  logic [7:0]       io_reg;
  logic [7:0]       test_reg;
  logic             onesec_reg;
  logic             rst_bit_reg;
  logic             force_frame_search_bit_reg;
  logic             ten_reg;
  logic [CNT_W-1:0] burst_cnt_reg;
  logic             burst_run_reg;
  logic             done_reg;
  logic [1:0]       txc_sync_reg;
  logic [1:0]       rxc_sync_reg;
  logic             txc_last_reg;
  logic             rxc_last_reg;
  logic [LOC_W-1:0] txc_cnt_reg;
  logic [LOC_W-1:0] rxc_cnt_reg;
  logic             loc_reg;
  logic [7:0]       rdata_next;
  logic [7:1]       summary;
  logic             atm;
  logic             test_rise;
  logic             wr_mode;
  logic             wr_io;
  logic             wr_test;
  logic             rd_sum;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  assign wr_mode = i_wr && hit(i_addr, dsuni_pkg::OFF_MODE);
  assign wr_io   = i_wr && hit(i_addr, dsuni_pkg::OFF_IO);
  assign wr_test = i_wr && hit(i_addr, dsuni_pkg::OFF_TEST);
  assign rd_sum  = i_rd && hit(i_addr, dsuni_pkg::OFF_ISUM);
  assign atm     = !test_reg[dsuni_pkg::TB_CLEAR];

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      mode_reg <= dsuni_pkg::MODE_RST;
    end else if (wr_mode) begin
      mode_reg <= i_wdata;
    end
  end

  // loss flag lives outside the stored byte, so a written bit 6 never touches it; writing bit 7 set clears it
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      io_reg <= dsuni_pkg::IO_RST;
    end else if (wr_io) begin
      io_reg <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      test_reg <= dsuni_pkg::TEST_RST;
    end else if (wr_test) begin
      test_reg <= i_wdata;
    end
  end

  // edge detectors on software bits; the pulse is one cycle long
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rst_bit_reg     <= 1'b0;
      force_frame_search_bit_reg <= 1'b0;
      ten_reg         <= 1'b0;
    end else begin
      rst_bit_reg     <= mode_reg[dsuni_pkg::MB_RST];
      force_frame_search_bit_reg <= io_reg[dsuni_pkg::IB_FORCE_FRAME_SEARCH];
      ten_reg         <= test_reg[dsuni_pkg::TB_EN];
    end
  end
  assign o_soft_reset = mode_reg[dsuni_pkg::MB_RST] && !rst_bit_reg;
  assign o_force_frame_search = io_reg[dsuni_pkg::IB_FORCE_FRAME_SEARCH]
                                && !force_frame_search_bit_reg;
  assign test_rise = test_reg[dsuni_pkg::TB_EN] && !ten_reg;

  // one-second flag: a tick in the read cycle survives the clear
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      onesec_reg <= 1'b0;
    end else if (i_one_second_tick) begin
      onesec_reg <= 1'b1;
    end else if (rd_sum) begin
      onesec_reg <= 1'b0;
    end
  end

  // sub-blocks hand in already-enabled pending levels, so no latch here
  always_comb begin
    summary = i_block_pending;
    if (!atm) begin
      summary = summary & ~dsuni_pkg::ATM_ONLY;
    end
    if (!atm || mode_reg[dsuni_pkg::MB_NOPLCP]) begin
      summary[dsuni_pkg::SB_PLCP] = 1'b0;
    end
  end

  // burst engine: counts sent cells after each enable rise
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      burst_cnt_reg <= '0;
      burst_run_reg <= 1'b0;
      done_reg      <= 1'b0;
    end else if (test_rise) begin
      burst_cnt_reg <= '0;
      burst_run_reg <= 1'b1;
      done_reg      <= 1'b0;
    end else if (!test_reg[dsuni_pkg::TB_EN]) begin
      burst_run_reg <= 1'b0;
    end else if (burst_run_reg && i_test_cell_sent) begin
      burst_cnt_reg <= burst_cnt_reg + 1'b1;
      if (burst_cnt_reg == BURST_N - 1'b1) begin
        burst_run_reg <= 1'b0;
        done_reg      <= 1'b1;
      end
    end
  end

  always_comb begin
    o_cfg.cell_loopback = atm && mode_reg[dsuni_pkg::MB_CLB];
    o_cfg.plcp_enable   = atm && !mode_reg[dsuni_pkg::MB_NOPLCP];
    o_cfg.plcp_loopback = o_cfg.plcp_enable
                          && mode_reg[dsuni_pkg::MB_PLB];
    o_cfg.framing_format_select = mode_reg[dsuni_pkg::MB_FMT];
    o_cfg.plcp_timing   = dsuni_pkg::dsuni_plcp_tm_e'(
                            mode_reg[dsuni_pkg::MB_TR1:dsuni_pkg::MB_TR0]);
    o_cfg.framer_timing = dsuni_pkg::dsuni_fr_tm_e'(
                            mode_reg[dsuni_pkg::MB_TR1:dsuni_pkg::MB_TR0]);
    // dual rail is software's duty when coding is on
    o_cfg.zero_substitution_enable = !io_reg[dsuni_pkg::IB_ZSOFF];
    o_cfg.single_rail     = io_reg[dsuni_pkg::IB_SRAIL];
    o_cfg.tx_clock_invert = io_reg[dsuni_pkg::IB_TXINV];
    o_cfg.rx_clock_invert = io_reg[dsuni_pkg::IB_RXINV];
    o_cfg.ien_auto_clear  = io_reg[dsuni_pkg::IB_IENCLR];
    o_cfg.clear_channel   = !atm;
    o_cfg.overhead_in_enable = atm && test_reg[dsuni_pkg::TB_OHIN];
    o_cfg.test_rcv_enable = test_reg[dsuni_pkg::TB_EN];
    if (atm && test_reg[dsuni_pkg::TB_ONESHOT]) begin
      o_cfg.test_gen_enable = burst_run_reg;
    end else begin
      o_cfg.test_gen_enable = test_reg[dsuni_pkg::TB_EN];
    end
  end

  // local loopback ahead of the receive rail samplers
  assign o_rx_positive_rail = mode_reg[dsuni_pkg::MB_LLB] ?
    i_tx_line_out_positive_rail : i_line_in_positive_rail;
  assign o_rx_negative_rail = mode_reg[dsuni_pkg::MB_LLB] ?
    i_tx_line_out_negative_rail : i_line_in_negative_rail;

  // line clocks are asynchronous pins; only the second stage is inspected
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      txc_sync_reg <= 2'b00;
      rxc_sync_reg <= 2'b00;
      txc_last_reg <= 1'b0;
      rxc_last_reg <= 1'b0;
    end else begin
      txc_sync_reg <= {txc_sync_reg[0], i_transmit_line_clock};
      rxc_sync_reg <= {rxc_sync_reg[0], i_receive_line_clock};
      txc_last_reg <= txc_sync_reg[1];
      rxc_last_reg <= rxc_sync_reg[1];
    end
  end

  // limitation: a line clock faster than half of i_clk_sys aliases
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || io_reg[dsuni_pkg::IB_LOCOFF]) begin
      txc_cnt_reg <= '0;
      rxc_cnt_reg <= '0;
      loc_reg     <= 1'b0;
    end else begin
      if (txc_sync_reg[1] != txc_last_reg) begin
        txc_cnt_reg <= '0;
      end else if (txc_cnt_reg != LOC_MAX) begin
        txc_cnt_reg <= txc_cnt_reg + 1'b1;
      end
      if (rxc_sync_reg[1] != rxc_last_reg) begin
        rxc_cnt_reg <= '0;
      end else if (rxc_cnt_reg != LOC_MAX) begin
        rxc_cnt_reg <= rxc_cnt_reg + 1'b1;
      end
      loc_reg <= (txc_cnt_reg == LOC_MAX) || (rxc_cnt_reg == LOC_MAX);
    end
  end

  always_comb begin
    rdata_next = dsuni_pkg::ZERO8;
    if (hit(i_addr, dsuni_pkg::OFF_MODE)) begin
      rdata_next = mode_reg;
    end else if (hit(i_addr, dsuni_pkg::OFF_IO)) begin
      rdata_next = io_reg;
      rdata_next[dsuni_pkg::IB_LOC] = loc_reg;
    end else if (hit(i_addr, dsuni_pkg::OFF_PART)) begin
      rdata_next = dsuni_pkg::PART_ID;
    end else if (hit(i_addr, dsuni_pkg::OFF_REV)) begin
      rdata_next = dsuni_pkg::REV_ID;
    end else if (hit(i_addr, dsuni_pkg::OFF_ISUM)) begin
      rdata_next = {summary, onesec_reg};
    end else if (hit(i_addr, dsuni_pkg::OFF_TEST)) begin
      rdata_next = {test_reg[dsuni_pkg::TB_CLEAR], test_reg[dsuni_pkg::TB_OHIN], 1'b0,
                    test_reg[dsuni_pkg::TB_EN], 1'b0,
                    test_reg[dsuni_pkg::TB_ONESHOT], done_reg, i_prbs_lock};
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_rdata <= dsuni_pkg::ZERO8;
    end else if (i_rd) begin
      o_rdata <= rdata_next;
    end
  end

  a_llb_route: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    mode_reg[dsuni_pkg::MB_LLB] |-> o_rx_positive_rail == i_tx_line_out_positive_rail)
    else $error("loopback rail not routed");
  a_soft_rst_pulse: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_soft_reset |=> !o_soft_reset)
    else $error("soft reset longer than one cycle");
  a_force_frame_search_edge: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $rose(io_reg[dsuni_pkg::IB_FORCE_FRAME_SEARCH]) |-> o_force_frame_search)
    else $error("force_frame_search edge missed");
  a_onesec_set: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_one_second_tick |=> onesec_reg)
    else $error("one-second flag not set");
  a_onesec_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    rd_sum && !i_one_second_tick |=> !onesec_reg)
    else $error("one-second flag not cleared by read");
  a_part_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_rd && i_addr == dsuni_pkg::OFF_PART |=> o_rdata == dsuni_pkg::PART_ID)
    else $error("part code wrong");
  a_loc_gated: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    io_reg[dsuni_pkg::IB_LOCOFF] |=> !loc_reg)
    else $error("clock loss reported while disabled");
  a_burst_done: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    burst_run_reg && i_test_cell_sent && test_reg[dsuni_pkg::TB_EN] && !test_rise
    && burst_cnt_reg == BURST_N - 1'b1 |=> done_reg && !burst_run_reg)
    else $error("burst did not end at count");
  a_plcp_mask: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !atm |-> (summary & dsuni_pkg::ATM_ONLY) == 7'h00)
    else $error("ATM-only summary active in clear channel");
  a_llb_neg: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    mode_reg[dsuni_pkg::MB_LLB] |-> o_rx_negative_rail == i_tx_line_out_negative_rail)
    else $error("loopback negative rail not routed");
  a_llb_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !mode_reg[dsuni_pkg::MB_LLB] |-> o_rx_positive_rail == i_line_in_positive_rail)
    else $error("receive rail not taken from pins");
  a_cell_lb_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_cfg.cell_loopback |-> atm && mode_reg[dsuni_pkg::MB_CLB])
    else $error("cell loopback outside ATM mode");
  a_plcp_lb_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_cfg.plcp_loopback |-> o_cfg.plcp_enable && mode_reg[dsuni_pkg::MB_PLB])
    else $error("PLCP loopback without PLCP mode");
  a_soft_rst_edge: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $rose(mode_reg[dsuni_pkg::MB_RST]) |-> o_soft_reset)
    else $error("soft reset edge missed");
  a_mode_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    wr_mode |=> mode_reg == $past(i_wdata))
    else $error("mode write lost");
  a_plcp_en_map: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_cfg.plcp_enable == (atm && !mode_reg[dsuni_pkg::MB_NOPLCP]))
    else $error("PLCP enable wrong");
  a_timing_map: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_cfg.plcp_timing == mode_reg[dsuni_pkg::MB_TR1:dsuni_pkg::MB_TR0]
    && o_cfg.framer_timing == mode_reg[dsuni_pkg::MB_TR1:dsuni_pkg::MB_TR0])
    else $error("timing code not passed on");
  a_loc_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_rd && i_addr == dsuni_pkg::OFF_IO |=> o_rdata[dsuni_pkg::IB_LOC] == $past(loc_reg))
    else $error("loss flag not read back");
  a_ien_map: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_cfg.ien_auto_clear == io_reg[dsuni_pkg::IB_IENCLR])
    else $error("interrupt enable clear option wrong");
  a_zs_map: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_cfg.zero_substitution_enable != io_reg[dsuni_pkg::IB_ZSOFF])
    else $error("zero substitution select wrong");
  a_io_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    wr_io |=> io_reg == $past(i_wdata))
    else $error("line control write lost");
  a_edge_map: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_cfg.tx_clock_invert == io_reg[dsuni_pkg::IB_TXINV]
    && o_cfg.rx_clock_invert == io_reg[dsuni_pkg::IB_RXINV])
    else $error("clock edge select wrong");
  a_force_frame_search_pulse: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_force_frame_search |=> !o_force_frame_search)
    else $error("frame search pulse too long");
  a_rev_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_rd && i_addr == dsuni_pkg::OFF_REV |=> o_rdata == dsuni_pkg::REV_ID)
    else $error("revision code wrong");
  a_sum_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_rd && i_addr == dsuni_pkg::OFF_ISUM |=> o_rdata == {$past(summary), $past(onesec_reg)})
    else $error("summary read wrong");
  a_plcp_direct: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    mode_reg[dsuni_pkg::MB_NOPLCP] |-> !summary[dsuni_pkg::SB_PLCP])
    else $error("PLCP summary active while direct mapped");
  a_onesec_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !i_one_second_tick && !rd_sum |=> $stable(onesec_reg))
    else $error("one-second flag changed unprompted");
  a_test_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    wr_test |=> test_reg == $past(i_wdata))
    else $error("test control write lost");
  a_cc_mode: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_cfg.clear_channel == test_reg[dsuni_pkg::TB_CLEAR])
    else $error("personality select wrong");
  a_ohin_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_cfg.overhead_in_enable == (atm && test_reg[dsuni_pkg::TB_OHIN]))
    else $error("overhead input enable wrong");
  a_gen_cont: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !atm |-> o_cfg.test_gen_enable == test_reg[dsuni_pkg::TB_EN])
    else $error("PRBS generator enable wrong");
  a_burst_start: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    test_rise |=> burst_run_reg && !done_reg && burst_cnt_reg == '0)
    else $error("burst did not restart");
  a_sum_drop: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_block_pending == 7'h00 |-> summary == 7'h00)
    else $error("summary set with nothing pending");
endmodule // dsuni_global_regs
`default_nettype wire

// ==== testbench/dsuni_host_model.sv ====
// Purpose: host processor model for the register strobes
// Assumes: one access per call, launched after a rising edge
// Notes:   forces dual rail whenever zero substitution is on
`timescale 1ns/1ps
`default_nettype none
module dsuni_host_model (
  input  wire logic       i_clk_sys,
  output var  logic [7:0] o_addr,
  output var  logic       o_wr,
  output var  logic       o_rd,
  output var  logic [7:0] o_wdata
);
  initial begin
    o_addr  = 8'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_wdata = 8'h00;
  end
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic [7:0] s);
    s = d;
    if (a == dsuni_pkg::OFF_IO && !d[4]) s[3] = 1'b0;
    @(posedge i_clk_sys);
    o_addr  <= a;
    o_wdata <= s;
    o_wr    <= 1'b1;
    @(posedge i_clk_sys);
    o_wr    <= 1'b0;
    o_wdata <= ~s;
  endtask
  task automatic read_reg(input logic [7:0] a);
    @(posedge i_clk_sys);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk_sys);
    o_rd   <= 1'b0;
  endtask
endmodule // dsuni_host_model
`default_nettype wire

// ==== testbench/dsuni_global_regs_tb_top.sv ====
// Purpose: self-checking bench for the global register group
// Assumes: host model drives strobes, bench drives sub-block pins
// Notes:   small loss and burst counts keep the run short
`timescale 1ns/1ps
`default_nettype none
module dsuni_global_regs_tb_top;
  localparam int LOC_T = 8;
  localparam int BRST  = 4;
  logic                  clk, rst_n, wr, rd, tick, sent, lock, txc, rxc, rx_run, rd_seen;
  logic                  tp, tn, rp, rn, orp, orn, sreset, fsearch;
  logic [7:0]            addr, wdata, rdata, v, w;
  logic [7:1]            pend;
  dsuni_pkg::dsuni_cfg_s cfg;
  logic [7:0]            expq[$];
  int                    failures, comparisons, cycles;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    txc = 1'b0;
    forever #7 txc = ~txc;
  end
  initial begin
    rxc = 1'b0;
    forever #9 rxc = rx_run ? ~rxc : rxc;
  end

  dsuni_host_model dsuni_host_model_i (.i_clk_sys(clk), .o_addr(addr), .o_wr(wr),
    .o_rd(rd), .o_wdata(wdata));
  dsuni_global_regs #(.LOC_CYCLES(LOC_T), .BURST(BRST)) dsuni_global_regs_i (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wr(wr), .i_rd(rd),
    .i_wdata(wdata), .o_rdata(rdata), .o_cfg(cfg), .o_soft_reset(sreset),
    .o_force_frame_search(fsearch), .i_block_pending(pend), .i_one_second_tick(tick),
    .i_test_cell_sent(sent), .i_prbs_lock(lock), .i_transmit_line_clock(txc),
    .i_receive_line_clock(rxc), .i_tx_line_out_positive_rail(tp),
    .i_tx_line_out_negative_rail(tn), .i_line_in_positive_rail(rp),
    .i_line_in_negative_rail(rn), .o_rx_positive_rail(orp), .o_rx_negative_rail(orn));

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    dsuni_host_model_i.read_reg(a);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    dsuni_host_model_i.write_reg(a, d, w);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic complete_run;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0 && expq.size() == 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // read data lands on the edge that takes the strobe and is compared one edge later
  always @(posedge clk) begin
    if (rd_seen && expq.size() > 0) check("rdata", rdata, expq.pop_front());
    rd_seen <= rd;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end

  initial begin
    {rst_n, tick, sent, lock, tp, tn, rp, rn} = '0;
    pend = '0;
    rx_run = 1'b1;
    void'($urandom(65659));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd_exp(dsuni_pkg::OFF_MODE, dsuni_pkg::MODE_RST);
    rd_exp(dsuni_pkg::OFF_IO, dsuni_pkg::IO_RST);
    rd_exp(dsuni_pkg::OFF_REV, dsuni_pkg::REV_ID);
    rd_exp(dsuni_pkg::OFF_TEST, dsuni_pkg::TEST_RST);
    wreg(dsuni_pkg::OFF_PART, 8'hFF);
    rd_exp(dsuni_pkg::OFF_PART, dsuni_pkg::PART_ID);
    rd_exp(8'h04, dsuni_pkg::ZERO8);
    // random mode traffic, timing codes cycled through all four values
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom);
      v[4] = 1'b0;
      v[1:0] = i[1:0];
      @(posedge clk);
      {tp, tn, rp, rn} <= 4'($urandom);
      wreg(dsuni_pkg::OFF_MODE, v);
      settle(1);
      check("fmt", cfg.framing_format_select, v[2]);
      check("plcp_en", cfg.plcp_enable, !v[3]);
      check("cell_lb", cfg.cell_loopback, v[6]);
      check("plcp_lb", cfg.plcp_loopback, v[5] & !v[3]);
      check("plcp_tm", cfg.plcp_timing, v[1:0]);
      check("fr_tm", cfg.framer_timing, v[1:0]);
      check("rx_pos", orp, v[7] ? tp : rp);
      check("rx_neg", orn, v[7] ? tn : rn);
      rd_exp(dsuni_pkg::OFF_MODE, v);
    end
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      v[7] = 1'b1;
      v[0] = 1'b0;
      wreg(dsuni_pkg::OFF_IO, v);
      settle(1);
      check("zs", cfg.zero_substitution_enable, !w[4]);
      check("rail", cfg.single_rail, w[3]);
      check("txinv", cfg.tx_clock_invert, w[2]);
      check("rxinv", cfg.rx_clock_invert, w[1]);
      check("ienclr", cfg.ien_auto_clear, w[5]);
      rd_exp(dsuni_pkg::OFF_IO, {w[7], 1'b0, w[5:0]});
    end
    wreg(dsuni_pkg::OFF_IO, 8'h81);
    #1 check("force_frame_search", fsearch, 1'b1);
    settle(1);
    check("force_frame_search", fsearch, 1'b0);
    wreg(dsuni_pkg::OFF_IO, 8'h81);
    #1 check("force_frame_search", fsearch, 1'b0);
    // loss detector enabled: flag only once the receive clock stops
    wreg(dsuni_pkg::OFF_IO, 8'h00);
    settle(LOC_T * 4);
    rd_exp(dsuni_pkg::OFF_IO, 8'h00);
    rx_run = 1'b0;
    settle(LOC_T * 8);
    rd_exp(dsuni_pkg::OFF_IO, 8'h40);
    rx_run = 1'b1;
    wreg(dsuni_pkg::OFF_MODE, 8'h1B);
    #1 check("soft_rst", sreset, 1'b1);
    settle(1);
    check("soft_rst", sreset, 1'b0);
    // summary masking per personality and mapping
    for (int i = 0; i < 4; i++) begin
      wreg(dsuni_pkg::OFF_TEST, {i[1], 7'h00});
      wreg(dsuni_pkg::OFF_MODE, {4'h0, i[0], 3'h3});
      @(posedge clk);
      pend <= 7'($urandom);
      settle(2);
      rd_exp(dsuni_pkg::OFF_ISUM, {pend[7], pend[6] & !i[0] & !i[1],
        pend[5:2] & ~{4{i[1]}}, pend[1], 1'b0});
    end
    @(posedge clk);
    pend <= '0;
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    settle(1);
    rd_exp(dsuni_pkg::OFF_ISUM, 8'h01);
    rd_exp(dsuni_pkg::OFF_ISUM, dsuni_pkg::ZERO8);
    wreg(dsuni_pkg::OFF_TEST, 8'h90);
    settle(1);
    check("cc", cfg.clear_channel, 1'b1);
    check("prbs_gen", cfg.test_gen_enable, 1'b1);
    check("prbs_rcv", cfg.test_rcv_enable, 1'b1);
    // one-shot burst in ATM mode stops after exactly BRST cells
    wreg(dsuni_pkg::OFF_TEST, 8'h04);
    wreg(dsuni_pkg::OFF_TEST, 8'h54);
    settle(1);
    check("oh_in", cfg.overhead_in_enable, 1'b1);
    check("cell_rcv", cfg.test_rcv_enable, 1'b1);
    for (int i = 0; i < BRST; i++) begin
      check("cell_gen", cfg.test_gen_enable, 1'b1);
      @(posedge clk);
      sent <= 1'b1;
      @(posedge clk);
      sent <= 1'b0;
      settle(1);
    end
    settle(1);
    check("cell_gen", cfg.test_gen_enable, 1'b0);
    @(posedge clk);
    lock <= 1'b1;
    settle(2);
    rd_exp(dsuni_pkg::OFF_TEST, 8'h57);
    settle(4);
    complete_run();
  end
endmodule // dsuni_global_regs_tb_top
`default_nettype wire
